// ### logic/aux_adc_control.sv
// register file and request/result control for three auxiliary converters
// assumes converters answer with accept and one-cycle done pulses
`timescale 1ns/1ps
`default_nettype none
module aux_adc_control #(
    parameter longint CYC_8MIN = aux_adc_pkg::PERIOD_8MIN_CYCLES,
    parameter longint CYC_2MIN = aux_adc_pkg::PERIOD_2MIN_CYCLES,
    parameter longint CYC_1MIN = aux_adc_pkg::PERIOD_1MIN_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic clock_en,
    input wire aux_adc_pkg::sfr_req_t special_function_register,
    output logic [7:0] sfr_rdata,
    input wire logic pll_lock_reset,
    input wire logic [2:0] conv_accept,
    input wire aux_adc_pkg::conv_done_t temp_done,
    input wire aux_adc_pkg::conv_done_t batt_done,
    input wire aux_adc_pkg::conv_done_t ext_done,
    output logic [2:0] conv_request,
    output logic temp_irq,
    output logic batt_irq,
    output logic ext_irq,
    output logic low_battery_flag,
    output logic pll_fault_flag
);
    typedef enum logic [1:0] {IDLE, SINGLE} track_t;

    logic [7:0] start_ff, nxt_start;
    logic [7:0] deltas_ff, nxt_deltas;
    logic [7:0] bthresh_ff, nxt_bthresh;
    logic [7:0] period_ff, nxt_period;
    logic [7:0] temp_res_ff, nxt_temp_res;
    logic [7:0] batt_res_ff, nxt_batt_res;
    logic [7:0] ext_res_ff, nxt_ext_res;
    logic [7:0] rdata_ff, nxt_rdata;
    logic pll_ff, nxt_pll;
    logic lowbat_ff, nxt_lowbat;
    logic tirq_ff, birq_ff, eirq_ff;
    logic nxt_tirq, nxt_birq, nxt_eirq;
    logic bg_req_ff, nxt_bg_req;
    track_t temp_trk_ff, nxt_temp_trk;
    track_t batt_trk_ff, nxt_batt_trk;
    track_t ext_trk_ff, nxt_ext_trk;
    logic bg_strobe;
    logic temp_chg, ext_chg;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = special_function_register.wr && (a == b);
    endfunction : hit

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    period_timer #(
        .CYC_8MIN(CYC_8MIN),
        .CYC_2MIN(CYC_2MIN),
        .CYC_1MIN(CYC_1MIN)
    ) u_timer (
        .clock(clock),
        .resetn(resetn),
        .enable(clock_en),
        .period(period_ff[aux_adc_pkg::TEMP_PERIOD_LSB +: 2]),
        .strobe(bg_strobe)
    );

    change_detect u_temp (
        .clock(clock),
        .resetn(resetn),
        .enable(clock_en),
        .delta(deltas_ff[aux_adc_pkg::TEMP_DELTA_LSB +: 3]),
        .force_irq(temp_trk_ff == SINGLE),
        .done(temp_done),
        .irq(temp_chg)
    );

    change_detect u_ext (
        .clock(clock),
        .resetn(resetn),
        .enable(clock_en),
        .delta(deltas_ff[aux_adc_pkg::EXT_DELTA_LSB +: 3]),
        .force_irq(ext_trk_ff == SINGLE),
        .done(ext_done),
        .irq(ext_chg)
    );

    // ------------------------------------------------------------------
    // register writes and start bits
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_start = start_ff;
        nxt_deltas = deltas_ff;
        nxt_bthresh = bthresh_ff;
        nxt_period = period_ff;
        nxt_pll = pll_ff;
        nxt_bg_req = bg_req_ff;
        if (hit(special_function_register.addr, aux_adc_pkg::ADDR_DELTAS))
            nxt_deltas = special_function_register.wdata & aux_adc_pkg::DELTA_MASK;
        if (hit(special_function_register.addr, aux_adc_pkg::ADDR_BATT_THRESH))
            nxt_bthresh = special_function_register.wdata;
        if (hit(special_function_register.addr, aux_adc_pkg::ADDR_PERIOD))
            nxt_period = special_function_register.wdata & aux_adc_pkg::PERIOD_MASK;
        if (conv_accept[aux_adc_pkg::BIT_EXT_START])
            nxt_start[aux_adc_pkg::BIT_EXT_START] = 1'b0;
        if (conv_accept[aux_adc_pkg::BIT_TEMP_START])
            nxt_start[aux_adc_pkg::BIT_TEMP_START] = 1'b0;
        if (conv_accept[aux_adc_pkg::BIT_BATT_START])
            nxt_start[aux_adc_pkg::BIT_BATT_START] = 1'b0;
        // a fresh start write wins over the accept of the last request
        if (hit(special_function_register.addr, aux_adc_pkg::ADDR_START))
            nxt_start = nxt_start | (special_function_register.wdata & aux_adc_pkg::START_MASK);
        if (bg_strobe)
            nxt_bg_req = 1'b1;
        else if (conv_accept[aux_adc_pkg::BIT_TEMP_START])
            nxt_bg_req = 1'b0;
        if (hit(special_function_register.addr, aux_adc_pkg::ADDR_START)
            && special_function_register.wdata[aux_adc_pkg::BIT_PLL_ACK])
            nxt_pll = 1'b0;
        if (pll_lock_reset)
            nxt_pll = 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            start_ff <= aux_adc_pkg::RESET_BYTE;
            deltas_ff <= aux_adc_pkg::RESET_BYTE;
            bthresh_ff <= aux_adc_pkg::RESET_BYTE;
            period_ff <= aux_adc_pkg::RESET_BYTE;
            bg_req_ff <= 1'b0;
        end
        else if (clock_en)
        begin
            start_ff <= nxt_start;
            deltas_ff <= nxt_deltas;
            bthresh_ff <= nxt_bthresh;
            period_ff <= nxt_period;
            bg_req_ff <= nxt_bg_req;
        end
    end

    // pll fault survives the core reset it was caused by
    always_ff @(posedge clock)
    begin
        if (clock_en || pll_lock_reset)
            pll_ff <= nxt_pll;
    end

    // ------------------------------------------------------------------
    // single conversion tracking
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_temp_trk = temp_trk_ff;
        nxt_batt_trk = batt_trk_ff;
        nxt_ext_trk = ext_trk_ff;
        if (temp_done.valid)
            nxt_temp_trk = IDLE;
        if (start_ff[aux_adc_pkg::BIT_TEMP_START]
            && conv_accept[aux_adc_pkg::BIT_TEMP_START])
            nxt_temp_trk = SINGLE;
        if (batt_done.valid)
            nxt_batt_trk = IDLE;
        if (start_ff[aux_adc_pkg::BIT_BATT_START]
            && conv_accept[aux_adc_pkg::BIT_BATT_START])
            nxt_batt_trk = SINGLE;
        if (ext_done.valid)
            nxt_ext_trk = IDLE;
        if (start_ff[aux_adc_pkg::BIT_EXT_START]
            && conv_accept[aux_adc_pkg::BIT_EXT_START])
            nxt_ext_trk = SINGLE;
    end

    // ------------------------------------------------------------------
    // results, flags and interrupts
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_tirq = temp_chg;
        nxt_eirq = ext_chg;
        nxt_birq = batt_done.valid
            && (batt_done.value < bthresh_ff || batt_trk_ff == SINGLE);
        nxt_temp_res = temp_chg ? temp_done.value : temp_res_ff;
        nxt_ext_res = ext_chg ? ext_done.value : ext_res_ff;
        nxt_batt_res = nxt_birq ? batt_done.value : batt_res_ff;
        nxt_lowbat = lowbat_ff;
        if (batt_done.valid && batt_done.value < bthresh_ff)
            nxt_lowbat = 1'b1;
        else if (batt_done.valid)
            nxt_lowbat = 1'b0;
        nxt_rdata = aux_adc_pkg::RESET_BYTE;
        if (special_function_register.rd)
        begin
            unique case (special_function_register.addr)
                aux_adc_pkg::ADDR_TEMP_RESULT: nxt_rdata = temp_res_ff;
                aux_adc_pkg::ADDR_START:
                    nxt_rdata = start_ff & aux_adc_pkg::START_MASK;
                aux_adc_pkg::ADDR_BATT_RESULT: nxt_rdata = batt_res_ff;
                aux_adc_pkg::ADDR_EXT_RESULT: nxt_rdata = ext_res_ff;
                aux_adc_pkg::ADDR_DELTAS: nxt_rdata = deltas_ff;
                aux_adc_pkg::ADDR_BATT_THRESH: nxt_rdata = bthresh_ff;
                aux_adc_pkg::ADDR_PERIOD: nxt_rdata = period_ff;
                default: nxt_rdata = aux_adc_pkg::RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            temp_res_ff <= aux_adc_pkg::RESET_BYTE;
            batt_res_ff <= aux_adc_pkg::RESET_BYTE;
            ext_res_ff <= aux_adc_pkg::RESET_BYTE;
            rdata_ff <= aux_adc_pkg::RESET_BYTE;
            lowbat_ff <= 1'b0;
            tirq_ff <= 1'b0;
            birq_ff <= 1'b0;
            eirq_ff <= 1'b0;
            temp_trk_ff <= IDLE;
            batt_trk_ff <= IDLE;
            ext_trk_ff <= IDLE;
        end
        else if (clock_en)
        begin
            temp_res_ff <= nxt_temp_res;
            batt_res_ff <= nxt_batt_res;
            ext_res_ff <= nxt_ext_res;
            rdata_ff <= nxt_rdata;
            lowbat_ff <= nxt_lowbat;
            tirq_ff <= nxt_tirq;
            birq_ff <= nxt_birq;
            eirq_ff <= nxt_eirq;
            temp_trk_ff <= nxt_temp_trk;
            batt_trk_ff <= nxt_batt_trk;
            ext_trk_ff <= nxt_ext_trk;
        end
    end

    assign sfr_rdata = rdata_ff;
    assign conv_request = {start_ff[aux_adc_pkg::BIT_EXT_START],
                           start_ff[aux_adc_pkg::BIT_TEMP_START]
                           | bg_req_ff,
                           start_ff[aux_adc_pkg::BIT_BATT_START]};
    assign temp_irq = tirq_ff;
    assign batt_irq = birq_ff;
    assign ext_irq = eirq_ff;
    assign low_battery_flag = lowbat_ff;
    assign pll_fault_flag = pll_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_temp_start_clear: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_en && conv_accept[aux_adc_pkg::BIT_TEMP_START]
        && !hit(special_function_register.addr, aux_adc_pkg::ADDR_START)
        |=> !start_ff[aux_adc_pkg::BIT_TEMP_START])
        else $error("temperature start bit not cleared");
    a_ext_start_clear: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_en && conv_accept[aux_adc_pkg::BIT_EXT_START]
        && !hit(special_function_register.addr, aux_adc_pkg::ADDR_START)
        |=> !start_ff[aux_adc_pkg::BIT_EXT_START])
        else $error("voltage start bit not cleared");
    a_batt_start_clear: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_en && conv_accept[aux_adc_pkg::BIT_BATT_START]
        && !hit(special_function_register.addr, aux_adc_pkg::ADDR_START)
        |=> !start_ff[aux_adc_pkg::BIT_BATT_START])
        else $error("battery start bit not cleared");
    a_pll_ack_clear: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_en && hit(special_function_register.addr, aux_adc_pkg::ADDR_START)
        && special_function_register.wdata[aux_adc_pkg::BIT_PLL_ACK] && !pll_lock_reset
        |=> !pll_fault_flag)
        else $error("pll fault not acknowledged");
    a_pll_fault_set: assert property (
        @(posedge clock) pll_lock_reset |=> pll_fault_flag)
        else $error("pll fault not set");
    a_batt_low_irq: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_en && batt_done.valid && batt_done.value < bthresh_ff
        |=> batt_irq && low_battery_flag)
        else $error("low battery not flagged");
    a_low_batt_clear: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_en && batt_done.valid && !(batt_done.value < bthresh_ff)
        |=> !low_battery_flag)
        else $error("low battery flag not cleared");
    a_temp_result_hold: assert property (
        @(posedge clock) disable iff (!resetn)
        !temp_irq |-> $stable(temp_res_ff) || $past(!resetn))
        else $error("temperature result changed without interrupt");
    a_batt_result_hold: assert property (
        @(posedge clock) disable iff (!resetn)
        !batt_irq |-> $stable(batt_res_ff) || $past(!resetn))
        else $error("battery result changed without interrupt");
    a_ext_result_hold: assert property (
        @(posedge clock) disable iff (!resetn)
        !ext_irq |-> $stable(ext_res_ff) || $past(!resetn))
        else $error("voltage result changed without interrupt");
    a_single_temp_irq: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_en && temp_trk_ff == SINGLE && temp_done.valid
        |=> temp_irq && temp_res_ff == $past(temp_done.value))
        else $error("single temperature conversion did not interrupt");
    a_ext_single_irq: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_en && ext_trk_ff == SINGLE && ext_done.valid
        |=> ext_irq && ext_res_ff == $past(ext_done.value))
        else $error("single voltage conversion did not interrupt");
    a_bg_request_set: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_en && bg_strobe
        |=> conv_request[aux_adc_pkg::BIT_TEMP_START])
        else $error("background temperature request not raised");
endmodule : aux_adc_control
`default_nettype wire

// ### logic/aux_adc_pkg.sv
// constants and carrier types for the auxiliary converter control block
// assumes a byte-wide special function register bus on one system clock
// ----------------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------------
package aux_adc_pkg;

    localparam logic [7:0] ADDR_TEMP_RESULT = 8'hD7;
    localparam logic [7:0] ADDR_START = 8'hD8;
    localparam logic [7:0] ADDR_BATT_RESULT = 8'hDF;
    localparam logic [7:0] ADDR_EXT_RESULT = 8'hEF;
    localparam logic [7:0] ADDR_DELTAS = 8'hF3;
    localparam logic [7:0] ADDR_BATT_THRESH = 8'hFA;
    localparam logic [7:0] ADDR_PERIOD = 8'hF9;

    localparam int BIT_BATT_START = 0;
    localparam int BIT_TEMP_START = 1;
    localparam int BIT_EXT_START = 2;
    localparam int BIT_PLL_ACK = 7;
    localparam int TEMP_DELTA_LSB = 3;
    localparam int EXT_DELTA_LSB = 0;
    localparam int TEMP_PERIOD_LSB = 0;

    localparam logic [7:0] START_MASK = 8'h07;
    localparam logic [7:0] DELTA_MASK = 8'h3F;
    localparam logic [7:0] PERIOD_MASK = 8'h03;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] DELTA_OFF = 3'h0;
    localparam logic [2:0] DELTA_ALL = 3'h7;
    localparam logic [1:0] PERIOD_OFF = 2'h0;
    localparam logic [1:0] PERIOD_8MIN = 2'h1;
    localparam logic [1:0] PERIOD_2MIN = 2'h2;

    localparam longint CLOCK_HZ = 125000000;
    localparam longint MINUTE_S = 60;
    localparam longint PERIOD_8MIN_CYCLES = 8 * MINUTE_S * CLOCK_HZ;
    localparam longint PERIOD_2MIN_CYCLES = 2 * MINUTE_S * CLOCK_HZ;
    localparam longint PERIOD_1MIN_CYCLES = 1 * MINUTE_S * CLOCK_HZ;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] value;
    } conv_done_t;

endpackage : aux_adc_pkg

// ### logic/change_detect.sv
// change detector: compares a fresh result with the last interrupting one
// assumes done pulses last one cycle and the delta code is stable
`timescale 1ns/1ps
`default_nettype none
module change_detect (
    input wire logic clock,
    input wire logic resetn,
    input wire logic enable,
    input wire logic [2:0] delta,
    input wire logic force_irq,
    input wire aux_adc_pkg::conv_done_t done,
    output logic irq
);
    logic [7:0] last_ff;
    logic [7:0] nxt_last;
    logic [7:0] diff;

    // ------------------------------------------------------------------
    // compare
    // ------------------------------------------------------------------
    always_comb
    begin
        diff = (done.value > last_ff) ? done.value - last_ff
                                      : last_ff - done.value;
        irq = 1'b0;
        if (done.valid)
        begin
            if (force_irq || delta == aux_adc_pkg::DELTA_ALL)
                irq = 1'b1;
            else if (delta != aux_adc_pkg::DELTA_OFF)
                irq = diff > {5'h00, delta};
        end
        nxt_last = irq ? done.value : last_ff;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            last_ff <= aux_adc_pkg::RESET_BYTE;
        else if (enable)
            last_ff <= nxt_last;
    end
endmodule : change_detect
`default_nettype wire

// ### logic/period_timer.sv
// background strobe timer for periodic temperature conversions
// assumes the period code comes straight from a register
`timescale 1ns/1ps
`default_nettype none
module period_timer #(
    parameter longint CYC_8MIN = aux_adc_pkg::PERIOD_8MIN_CYCLES,
    parameter longint CYC_2MIN = aux_adc_pkg::PERIOD_2MIN_CYCLES,
    parameter longint CYC_1MIN = aux_adc_pkg::PERIOD_1MIN_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic enable,
    input wire logic [1:0] period,
    output logic strobe
);
    logic [35:0] count_ff;
    logic [35:0] nxt_count;
    logic [35:0] limit;

    // ------------------------------------------------------------------
    // interval count
    // ------------------------------------------------------------------
    always_comb
    begin
        unique case (period)
            aux_adc_pkg::PERIOD_8MIN: limit = 36'(CYC_8MIN - 1);
            aux_adc_pkg::PERIOD_2MIN: limit = 36'(CYC_2MIN - 1);
            default: limit = 36'(CYC_1MIN - 1);
        endcase
        strobe = 1'b0;
        nxt_count = count_ff + 36'h1;
        if (period == aux_adc_pkg::PERIOD_OFF)
            nxt_count = 36'h0;
        else if (count_ff >= limit)
        begin
            strobe = 1'b1;
            nxt_count = 36'h0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            count_ff <= 36'h0;
        else if (enable)
            count_ff <= nxt_count;
    end
endmodule : period_timer
`default_nettype wire

// ### test/aux_adc_measure_control_tb_top.sv
// testbench for the auxiliary converter control block
// assumes the converter model answers the start requests
`timescale 1ns/1ps
`default_nettype none
module aux_adc_measure_control_tb_top;
    localparam longint CYC8 = 40;
    localparam longint CYC2 = 20;
    localparam longint CYC1 = 10;
    localparam longint PER [4] = '{0, CYC8, CYC2, CYC1};
    logic clock;
    logic resetn;
    logic clock_en;
    logic pll_lock_reset;
    aux_adc_pkg::sfr_req_t special_function_register;
    logic [7:0] sfr_rdata;
    logic [2:0] conv_accept;
    logic [2:0] conv_request;
    aux_adc_pkg::conv_done_t temp_done;
    aux_adc_pkg::conv_done_t batt_done;
    aux_adc_pkg::conv_done_t ext_done;
    logic temp_irq;
    logic batt_irq;
    logic ext_irq;
    logic low_battery_flag;
    logic pll_fault_flag;
    logic [3:0] accept_delay;
    logic [23:0] values;
    logic [2:0] irq_v;
    logic [2:0] done_v;
    logic [7:0] regs [8];
    int fail_count;
    int checks;
    int gap;
    int n;
    longint t0;

    assign irq_v = {ext_irq, temp_irq, batt_irq};
    assign done_v = {ext_done.valid, temp_done.valid, batt_done.valid};

    aux_adc_control #(
        .CYC_8MIN(CYC8),
        .CYC_2MIN(CYC2),
        .CYC_1MIN(CYC1)
    ) u_aux_adc_control (
        .clock(clock), .resetn(resetn), .clock_en(clock_en),
        .special_function_register(special_function_register), .sfr_rdata(sfr_rdata), .pll_lock_reset(pll_lock_reset),
        .conv_accept(conv_accept), .temp_done(temp_done),
        .batt_done(batt_done), .ext_done(ext_done),
        .conv_request(conv_request), .temp_irq(temp_irq),
        .batt_irq(batt_irq), .ext_irq(ext_irq),
        .low_battery_flag(low_battery_flag), .pll_fault_flag(pll_fault_flag)
    );

    conv_model u_conv_model (
        .clock(clock), .resetn(resetn), .conv_request(conv_request),
        .accept_delay(accept_delay), .values(values),
        .conv_accept(conv_accept), .batt_done(batt_done),
        .temp_done(temp_done), .ext_done(ext_done)
    );

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic summarize();
        if (fail_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask : check

    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        special_function_register.wr = 1'b1;
        special_function_register.addr = addr;
        special_function_register.wdata = data;
        @(negedge clock);
        special_function_register.wr = 1'b0;
        @(negedge clock);
    endtask : sfr_write

    task automatic sfr_read(input logic [7:0] addr, input logic [7:0] exp);
        special_function_register.rd = 1'b1;
        special_function_register.addr = addr;
        @(negedge clock);
        special_function_register.rd = 1'b0;
        check(sfr_rdata, exp);
        @(negedge clock);
    endtask : sfr_read

    // kind 0 accept, 1 done, 2 request high, 3 request low
    task automatic wait_for(input int kind, input int ch);
        logic [2:0] v;
        int k;
        for (k = 0; k < 200; k++)
        begin
            @(negedge clock);
            v = (kind == 0) ? conv_accept : (kind == 1) ? done_v :
                (kind == 2) ? conv_request : ~conv_request;
            if (v[ch] === 1'b1)
                break;
        end
        if (k == 200)
        begin
            fail_count++;
            $display("unexpected at %0t: wait ran out", $time);
            summarize();
        end
    endtask : wait_for

    task automatic single(input int ch, input logic [3:0] dly,
                          input logic [7:0] val, input logic [7:0] addr);
        accept_delay = dly;
        values[8 * ch +: 8] = val;
        sfr_write(aux_adc_pkg::ADDR_START, 8'(1 << ch));
        sfr_read(aux_adc_pkg::ADDR_START, 8'(1 << ch));
        wait_for(0, ch);
        @(negedge clock);
        check({7'h00, conv_request[ch]}, 8'h00);
        wait_for(1, ch);
        @(negedge clock);
        check({7'h00, irq_v[ch]}, 8'h01);
        sfr_read(addr, val);
    endtask : single

    task automatic bg_step(input logic [2:0] delta, input logic [7:0] val,
                           input logic hit, input logic [7:0] res);
        sfr_write(aux_adc_pkg::ADDR_DELTAS, {2'h0, delta, 3'h0});
        values[15:8] = val;
        wait_for(1, 1);
        @(negedge clock);
        check({7'h00, temp_irq}, {7'h00, hit});
        sfr_read(aux_adc_pkg::ADDR_TEMP_RESULT, res);
    endtask : bg_step

    // ------------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial
    begin
        resetn = 1'b0;
        clock_en = 1'b1;
        pll_lock_reset = 1'b0;
        special_function_register = '0;
        accept_delay = 4'h1;
        values = 24'h000000;
        fail_count = 0;
        checks = 0;
        regs = '{aux_adc_pkg::ADDR_TEMP_RESULT, aux_adc_pkg::ADDR_START,
                 aux_adc_pkg::ADDR_BATT_RESULT, aux_adc_pkg::ADDR_EXT_RESULT,
                 aux_adc_pkg::ADDR_DELTAS, aux_adc_pkg::ADDR_BATT_THRESH,
                 aux_adc_pkg::ADDR_PERIOD, 8'h00};
        repeat (8) @(negedge clock);
        resetn = 1'b1;
        for (int i = 0; i < 8; i++)
            sfr_read(regs[i], 8'h00);
        pll_lock_reset = 1'b1;
        @(negedge clock);
        pll_lock_reset = 1'b0;
        repeat (4) @(negedge clock);
        check({7'h00, pll_fault_flag}, 8'h01);
        sfr_write(aux_adc_pkg::ADDR_START, 8'hF8);
        check({7'h00, pll_fault_flag}, 8'h00);
        sfr_read(aux_adc_pkg::ADDR_START, 8'h00);
        sfr_write(aux_adc_pkg::ADDR_DELTAS, 8'hFF);
        sfr_read(aux_adc_pkg::ADDR_DELTAS, 8'h3F);
        sfr_write(aux_adc_pkg::ADDR_DELTAS, 8'h00);
        sfr_write(aux_adc_pkg::ADDR_BATT_THRESH, 8'h80);
        sfr_read(aux_adc_pkg::ADDR_BATT_THRESH, 8'h80);
        // a write while the clock enable is low must not land
        clock_en = 1'b0;
        sfr_write(aux_adc_pkg::ADDR_BATT_THRESH, 8'h11);
        clock_en = 1'b1;
        sfr_read(aux_adc_pkg::ADDR_BATT_THRESH, 8'h80);
        single(1, 4'h6, 8'h40, aux_adc_pkg::ADDR_TEMP_RESULT);
        single(2, 4'h2, 8'hA5, aux_adc_pkg::ADDR_EXT_RESULT);
        single(0, 4'h2, 8'h7F, aux_adc_pkg::ADDR_BATT_RESULT);
        check({7'h00, low_battery_flag}, 8'h01);
        single(0, 4'h3, 8'h80, aux_adc_pkg::ADDR_BATT_RESULT);
        check({7'h00, low_battery_flag}, 8'h00);
        // background temperature against the last interrupting value
        accept_delay = 4'h0;
        sfr_write(aux_adc_pkg::ADDR_PERIOD, 8'h03);
        bg_step(3'h0, 8'h7F, 1'b0, 8'h40);
        bg_step(3'h7, 8'h7F, 1'b1, 8'h7F);
        bg_step(3'h3, 8'h7C, 1'b0, 8'h7F);
        bg_step(3'h3, 8'h7B, 1'b1, 8'h7B);
        bg_step(3'h6, 8'h81, 1'b0, 8'h7B);
        bg_step(3'h1, 8'h7F, 1'b1, 8'h7F);
        for (int code = 1; code < 4; code++)
        begin
            sfr_write(aux_adc_pkg::ADDR_PERIOD, 8'(code));
            wait_for(2, 1);
            wait_for(3, 1);
            wait_for(2, 1);
            t0 = $time;
            wait_for(3, 1);
            wait_for(2, 1);
            gap = int'(($time - t0) / 8);
            check({7'h00, gap >= PER[code] - 1 && gap <= PER[code] + 1},
                  8'h01);
        end
        sfr_write(aux_adc_pkg::ADDR_PERIOD, 8'h00);
        repeat (20) @(negedge clock);
        n = 0;
        repeat (100)
        begin
            @(negedge clock);
            n += int'(conv_request[1]);
        end
        check(8'(n), 8'h00);
        resetn = 1'b0;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        sfr_read(aux_adc_pkg::ADDR_BATT_THRESH, 8'h00);
        sfr_read(aux_adc_pkg::ADDR_TEMP_RESULT, 8'h00);
        summarize();
    end
endmodule : aux_adc_measure_control_tb_top
`default_nettype wire

// ### test/conv_model.sv
// converter model: three converters that accept a request, then report
// assumes start requests are levels held by the block until accepted
`timescale 1ns/1ps
`default_nettype none
module conv_model #(
    parameter int CONV_CYCLES = 4
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [2:0] conv_request,
    input wire logic [3:0] accept_delay,
    input wire logic [23:0] values,
    output logic [2:0] conv_accept,
    output aux_adc_pkg::conv_done_t batt_done,
    output aux_adc_pkg::conv_done_t temp_done,
    output aux_adc_pkg::conv_done_t ext_done
);
    // ------------------------------------------------------------------
    // per converter: wait, accept, convert, report
    // ------------------------------------------------------------------
    logic [1:0] phase [3];
    logic [4:0] cnt [3];
    aux_adc_pkg::conv_done_t done [3];

    always_ff @(posedge clock)
    begin
        for (int ch = 0; ch < 3; ch++)
        begin
            conv_accept[ch] <= 1'b0;
            done[ch].valid <= 1'b0;
            // idle result lines change every cycle
            done[ch].value <= ~done[ch].value;
            if (!resetn)
            begin
                phase[ch] <= 2'h0;
                cnt[ch] <= 5'h00;
                done[ch].value <= 8'h5A;
            end
            else if (phase[ch] == 2'h0 && conv_request[ch])
            begin
                phase[ch] <= 2'h1;
                cnt[ch] <= {1'b0, accept_delay};
            end
            else if (phase[ch] != 2'h0 && cnt[ch] != 5'h00)
            begin
                cnt[ch] <= cnt[ch] - 5'h01;
            end
            else if (phase[ch] == 2'h1)
            begin
                conv_accept[ch] <= 1'b1;
                phase[ch] <= 2'h2;
                cnt[ch] <= 5'(CONV_CYCLES);
            end
            else if (phase[ch] == 2'h2)
            begin
                done[ch].valid <= 1'b1;
                done[ch].value <= values[8 * ch +: 8];
                phase[ch] <= 2'h0;
            end
        end
    end

    assign batt_done = done[0];
    assign temp_done = done[1];
    assign ext_done = done[2];
endmodule : conv_model
`default_nettype wire
